// ---- dv/dspacc_core_model.sv ----
// Decoder side model: issues one decoded request per clock.
// Assumes calls start right after reset release, one at a time.
`timescale 1ns/1ps
`default_nettype none
module dspacc_core_model
	import dspacc_pkg::*;
(
	input wire logic clk,
	output dspacc_req_type req
);
	initial req = '0;
	// Holds a request for n edges, then idles with scrambled bus lines
	task automatic op(input dspacc_req_type r, input int n);
		dspacc_req_type z;
		z = r;
		z.valid = 1'b0;
		z.xbus = ~r.xbus;
		z.product = ~r.product;
		@(posedge clk);
		req <= r;
		repeat (n) @(posedge clk);
		req <= z;
	endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the accumulator datapath.
// Assumes the core model drives requests; bench drives the register port.
`timescale 1ns/1ps
`default_nettype none
`include "dspacc_params.svh"
module testbench
	import dspacc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	dspacc_req_type req;
	dspacc_status_type status;
	logic trap_req;
	dspacc_dwrite_type dwrite;
	logic [39:0] shift_result;
	logic [15:0] core_shift_result;
	logic [39:0] acc_a_out;
	logic [39:0] acc_b_out;
	int num_errors = 0;
	int checked = 0;
	dspacc_core_model core (.clk(clk), .req(req));
	dspacc_datapath DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req),
		.status(status), .trap_req(trap_req), .dwrite(dwrite), .shift_result(shift_result),
		.core_shift_result(core_shift_result), .acc_a_out(acc_a_out), .acc_b_out(acc_b_out));
	initial forever #12.5 clk = ~clk;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [39:0] s, input logic [39:0] e);
		checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	function automatic dspacc_req_type mk(input dspacc_op_type c, input logic b,
		input dspacc_src_type s, input logic signed [5:0] a, input logic [15:0] x,
		input logic [32:0] p);
		dspacc_req_type q;
		q = '0;
		q.valid = 1'b1;
		q.code = c;
		q.target_b = b;
		q.shift_src = s;
		q.shift_arith = 1'b1;
		q.shift_amt = a;
		q.xbus = x;
		q.product = p;
		q.store_addr = 16'h0200;
		return q;
	endfunction
	function automatic dspacc_req_type ar(input dspacc_op_type c, input logic b,
		input logic [32:0] p);
		return mk(c, b, src_acc_a, 6'sd0, 16'h0000, p);
	endfunction
	task automatic go(input dspacc_req_type q, input int n);
		core.op(q, n);
		#1;
	endtask
	task automatic st(input dspacc_op_type c, input logic b, input logic [15:0] e);
		go(ar(c, b, 33'h0), 1);
		chk(dwrite.valid, 1'b1);
		chk(dwrite.addr, 16'h0200);
		chk(dwrite.data, e);
	endtask
	task automatic t_reset();
		rd(4'h0, 16'h0000);
		rd(4'h2, 16'h0000);
		rd(4'hf, 16'h0000);
		wr(4'h4, 16'h1234);
		rd(4'h4, 16'h0000);
		chk(acc_a_out, 40'h0);
	endtask
	task automatic t_sat32();
		wr(4'h0, 16'h00c0);
		go(ar(op_multiply_accumulate, 1'b0, 33'h0ffffffff), 3);
		chk(acc_a_out, `DSPACC_SAT32_POS);
		chk(status, 6'h09);
		go(ar(op_multiply_subtract, 1'b1, 33'h0ffffffff), 1);
		chk(acc_b_out, `DSPACC_SAT32_NEG);
		chk(status, 6'h0d);
		wr(4'h0, 16'h0000);
		go(ar(op_multiply_to_acc, 1'b0, 33'h0), 1);
		chk(status, 6'h0d);
		rd(4'h2, 16'h000d);
		wr(4'h2, 16'h0008);
		rd(4'h2, 16'h0005);
		wr(4'h2, 16'h0004);
		rd(4'h2, 16'h0000);
	endtask
	task automatic t_guard();
		wr(4'h1, 16'h0001);
		go(ar(op_multiply_accumulate, 1'b0, 33'h0ffffffff), 2);
		chk(acc_a_out, 40'h01fffffffe);
		chk(status, 6'h22);
		chk(trap_req, 1'b1);
		go(ar(op_multiply_accumulate, 1'b0, 33'h0), 1);
		chk(trap_req, 1'b0);
	endtask
	task automatic t_cat();
		wr(4'h1, 16'h0004);
		go(ar(op_multiply_to_acc, 1'b0, 33'h0), 1);
		go(ar(op_multiply_accumulate, 1'b0, 33'h0ffffffff), 129);
		chk(acc_a_out, 40'h80ffffff7f);
		chk(status, 6'h2b);
		chk(trap_req, 1'b1);
		rd(4'h6, 16'h0080);
		wr(4'h2, 16'h0008);
	endtask
	task automatic t_sat40();
		wr(4'h1, 16'h0000);
		wr(4'h0, 16'h0090);
		go(ar(op_multiply_to_acc, 1'b0, 33'h0), 1);
		go(ar(op_multiply_accumulate, 1'b0, 33'h0ffffffff), 129);
		chk(acc_a_out, `DSPACC_SAT40_POS);
		chk(status.acc_a_sat_flag, 1'b1);
		go(ar(op_multiply_to_acc, 1'b0, 33'h0), 1);
		go(ar(op_multiply_subtract, 1'b0, 33'h0ffffffff), 129);
		chk(acc_a_out, `DSPACC_SAT40_NEG);
		wr(4'h2, 16'h0008);
		wr(4'h0, 16'h0000);
	endtask
	task automatic t_shift();
		dspacc_req_type q;
		go(mk(op_load_acc, 1'b0, src_xbus, 6'sd4, 16'h1234, 33'h0), 1);
		chk(acc_a_out, 40'h0001234000);
		go(mk(op_load_acc, 1'b0, src_xbus, -6'sd4, 16'h1234, 33'h0), 1);
		chk(acc_a_out, 40'h0000012340);
		go(mk(op_add_acc, 1'b0, src_xbus, 6'sd16, 16'h0001, 33'h0), 1);
		chk(acc_a_out, 40'h0000012341);
		go(mk(op_sub_acc, 1'b0, src_xbus, 6'sd16, 16'h0002, 33'h0), 1);
		chk(acc_a_out, 40'h000001233f);
		go(ar(op_multiply_to_acc, 1'b0, 33'h100000001), 1);
		chk(acc_a_out, 40'hff00000001);
		q = mk(op_shift, 1'b0, src_acc_a, 6'sd4, 16'h0000, 33'h0);
		go(q, 1);
		chk(shift_result, 40'hfff0000000);
		q.shift_arith = 1'b0;
		go(q, 1);
		chk(shift_result, 40'h0ff0000000);
		go(mk(op_shift, 1'b0, src_acc_a, -6'sd4, 16'h0000, 33'h0), 1);
		chk(shift_result, 40'hf000000010);
		go(mk(op_shift, 1'b0, src_acc_a, 6'sd0, 16'h0000, 33'h0), 1);
		chk(shift_result, 40'hff00000001);
		go(mk(op_shift, 1'b0, src_acc_a, 6'sd16, 16'h0000, 33'h0), 1);
		chk(shift_result, 40'hffffff0000);
		go(mk(op_shift, 1'b0, src_xbus, 6'sd4, 16'h8234, 33'h0), 1);
		chk(core_shift_result, 16'hf823);
		go(mk(op_shift, 1'b0, src_xbus, -6'sd4, 16'h8234, 33'h0), 1);
		chk(core_shift_result, 16'h2340);
	endtask
	task automatic t_round();
		wr(4'h0, 16'h0002);
		go(mk(op_load_acc, 1'b0, src_xbus, -6'sd15, 16'h0001, 33'h0), 1);
		go(mk(op_load_acc, 1'b1, src_xbus, -6'sd15, 16'h0003, 33'h0), 1);
		st(op_store_acc_rounded, 1'b0, 16'h0001);
		st(op_store_acc_rounded, 1'b1, 16'h0002);
		wr(4'h0, 16'h0000);
		st(op_store_acc_rounded, 1'b0, 16'h0000);
		st(op_store_acc_rounded, 1'b1, 16'h0002);
		st(op_store_acc_trunc, 1'b1, 16'h0001);
	endtask
	task automatic t_dwsat();
		go(ar(op_multiply_to_acc, 1'b0, 33'h100000001), 1);
		go(ar(op_multiply_to_acc, 1'b1, 33'h0ffffffff), 1);
		wr(4'h0, 16'h0020);
		st(op_store_acc_trunc, 1'b1, 16'h7fff);
		st(op_store_acc_trunc, 1'b0, 16'h8000);
		chk(acc_b_out, 40'h00ffffffff);
		wr(4'h0, 16'h0000);
		st(op_store_acc_trunc, 1'b1, 16'hffff);
		st(op_store_acc_trunc, 1'b0, 16'h0000);
	endtask
	task automatic t_wb();
		dspacc_req_type q;
		go(mk(op_load_acc, 1'b1, src_xbus, -6'sd15, 16'h0003, 33'h0), 1);
		wr(4'h3, 16'h0100);
		q = ar(op_multiply_accumulate, 1'b0, 33'h0);
		q.wb_en = 1'b1;
		q.wb_indirect = 1'b1;
		go(q, 1);
		chk(dwrite.valid, 1'b1);
		chk(dwrite.addr, 16'h0100);
		chk(dwrite.data, 16'h0002);
		rd(4'h3, 16'h0102);
		q.wb_indirect = 1'b0;
		go(q, 1);
		chk(dwrite.to_pointer, 1'b1);
		rd(4'h3, 16'h0002);
		q.code = op_multiply_to_acc;
		go(q, 1);
		chk(dwrite.valid, 1'b0);
		q.code = op_distance_squared;
		go(q, 1);
		chk(dwrite.valid, 1'b0);
	endtask
	initial
	begin
		#100us;
		num_errors++;
		tally_and_finish();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		$display("reset test done");
		t_sat32();
		$display("sat32 test done");
		t_guard();
		$display("guard test done");
		t_cat();
		$display("wrap test done");
		t_sat40();
		$display("sat40 test done");
		t_shift();
		$display("shift test done");
		t_round();
		$display("round test done");
		t_dwsat();
		$display("write saturation test done");
		t_wb();
		$display("write-back test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ---- rtl/dspacc_datapath.sv ----
// Accumulator datapath: adder, saturation, rounding, write-back, shifter.
// Assumes one decoded request per cycle and shift amounts within -16..16.
// Overview of operation
// - 40-bit adder on selectable accumulator, written back
// - Add true plus carry, subtract complement plus borrow
// - Guard flag set when bits 39..32 differ
// - Guard flag rising with enable raises trap
// - Saturation flags sticky, cleared only by software
// - Saturation off: flag marks bit 39, may trap
// - Combined flags are OR of both accumulators
// - Saturation steered by enables and width select
// - 40-bit mode clamps to 9.31 extremes
// - 32-bit mode clamps to 40'h007fffffff or 40'h0080000000 (guard bits zero on both)
// - 32-bit mode never sets guard flags
// - Catastrophic mode wraps, sets sticky flag
// - Multiply-accumulate and multiply-subtract may write back other accumulator
// - Write-back to pointer or via it, step two
// - Conventional rounding adds bit 15 to high
// - Convergent rounding ties on bit 16
// - Unrounded store truncates; write-back always rounds
// - Data-write saturation clamps to 1.15 extremes
// - Sign from bit 39; disabled passes through
// - Shift up to 16 bits from acc or bus
// - Signed amount: positive right, negative left, zero keeps
// - Bus data enters high or low half
// - Product sign-extended to 40 bits before adder
`timescale 1ns/1ps
`default_nettype none
`include "dspacc_params.svh"
module dspacc_datapath
	import dspacc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire dspacc_req_type req,
	output dspacc_status_type status,
	output logic trap_req,
	output dspacc_dwrite_type dwrite,
	output logic [39:0] shift_result,
	output logic [15:0] core_shift_result,
	output logic [39:0] acc_a_out,
	output logic [39:0] acc_b_out
);
	localparam dspacc_state_type state_rst = '{
		acc_a: `DSPACC_ACC_RST,
		acc_b: `DSPACC_ACC_RST,
		st: '0,
		ctrl: `DSPACC_CORE_CONTROL_RST,
		trapc: `DSPACC_TRAP_CONTROL_RST,
		ptr: `DSPACC_PTR_RST,
		rdata: '0,
		trap: 1'b0,
		wr: '0,
		shift: '0,
		core_shift: '0
	};

	dspacc_state_type q;
	dspacc_state_type d;
	logic fire;
	logic to_b;
	logic arith_op;
	logic zero_in;
	logic subtract;
	logic is_product;
	logic wb_go;
	logic sat_en;
	logic wide;
	logic mode32_a;
	logic mode32_b;
	logic sh_left;
	logic [5:0] sh_mag;
	logic [39:0] tgt_acc;
	logic [39:0] oth_acc;
	logic [39:0] sh_src;
	logic [39:0] sh_res;
	logic [39:0] opnd;
	logic [39:0] add_a;
	logic [39:0] add_b;
	logic [39:0] sum;
	logic [39:0] sat_val;
	logic [39:0] res;
	logic ov39;
	logic ov31;
	logic neg;
	logic sat_hit;
	logic sat_set;
	logic [15:0] wb_data;
	logic [15:0] st_data;
	logic [15:0] rnd_ref;

	// Guard bits not all equal
	function automatic logic dspacc_guard_bad(input logic [39:0] v);
		return !((&v[`DSPACC_GUARD_MSB:`DSPACC_GUARD_LSB])
			|| !(|v[`DSPACC_GUARD_MSB:`DSPACC_GUARD_LSB]));
	endfunction

	// Round or truncate high word, then optional data-write clamp
	function automatic logic [15:0] dspacc_wb_word(input logic [39:0] a,
		input logic rnd, input logic conv, input logic data_write_sat_en);
		logic inc;
		logic [23:0] r;
		logic [15:0] w;
		inc = rnd && a[15] && (conv || (a[15:0] != `DSPACC_RND_HALF) || a[16]);
		r = a[39:16] + {23'h000000, inc};
		w = r[15:0];
		if (data_write_sat_en && !a[39] && (r > `DSPACC_DW_POS_LIMIT))
			w = `DSPACC_DW_POS_MAX;
		if (data_write_sat_en && a[39] && (r < `DSPACC_DW_NEG_LIMIT))
			w = `DSPACC_DW_NEG_MAX;
		return w;
	endfunction

	// Request decode
	assign fire = req.valid;
	assign to_b = req.target_b;
	assign arith_op = fire && (req.code inside {op_load_acc, op_add_acc, op_sub_acc,
		op_multiply_to_acc, op_negated_multiply_to_acc, op_multiply_accumulate,
		op_multiply_subtract, op_distance_squared, op_distance_squared_accumulate});
	assign zero_in = req.code inside {op_load_acc, op_multiply_to_acc,
		op_negated_multiply_to_acc, op_distance_squared};
	assign subtract = req.code inside {op_sub_acc, op_negated_multiply_to_acc,
		op_multiply_subtract};
	assign is_product = req.code inside {op_multiply_to_acc, op_negated_multiply_to_acc,
		op_multiply_accumulate, op_multiply_subtract, op_distance_squared,
		op_distance_squared_accumulate};
	assign wb_go = fire && req.wb_en
		&& (req.code inside {op_multiply_accumulate, op_multiply_subtract});
	assign tgt_acc = to_b ? q.acc_b : q.acc_a;
	assign oth_acc = to_b ? q.acc_a : q.acc_b;

	// Barrel shifter
	assign sh_left = req.shift_amt[5];
	assign sh_mag = sh_left ? (~req.shift_amt + 6'h01) : req.shift_amt;
	always_comb
	begin
		case (req.shift_src)
			src_acc_a: sh_src = q.acc_a;
			src_acc_b: sh_src = q.acc_b;
			default: sh_src = sh_left ? {24'h000000, req.xbus}
				: {{8{req.shift_arith & req.xbus[15]}}, req.xbus, 16'h0000};
		endcase
	end
	assign sh_res = sh_left ? (sh_src << sh_mag)
		: (req.shift_arith ? 40'($signed(sh_src) >>> sh_mag) : (sh_src >> sh_mag));

	// Adder and saturation
	assign opnd = is_product ? {{7{req.product[32]}}, req.product} : sh_res;
	assign add_a = zero_in ? 40'h0000000000 : tgt_acc;
	assign add_b = subtract ? ~opnd : opnd;
	assign sum = add_a + add_b + {39'h0000000000, subtract};
	assign ov39 = (add_a[39] == add_b[39]) && (sum[39] != add_a[39]);
	assign ov31 = ov39 || !((&sum[39:31]) || !(|sum[39:31]));
	assign sat_en = to_b ? q.ctrl[`DSPACC_CC_SAT_B_BIT] : q.ctrl[`DSPACC_CC_SAT_A_BIT];
	assign wide = q.ctrl[`DSPACC_CC_WIDTH_BIT];
	assign mode32_a = q.ctrl[`DSPACC_CC_SAT_A_BIT] && !wide;
	assign mode32_b = q.ctrl[`DSPACC_CC_SAT_B_BIT] && !wide;
	assign neg = ov39 ? add_a[39] : sum[39];
	assign sat_hit = sat_en && (wide ? ov39 : ov31);
	assign sat_set = sat_en ? sat_hit : ov39;
	assign sat_val = wide ? (neg ? `DSPACC_SAT40_NEG : `DSPACC_SAT40_POS)
		: (neg ? `DSPACC_SAT32_NEG : `DSPACC_SAT32_POS);
	assign res = sat_hit ? sat_val : sum;

	// Store data paths
	assign wb_data = dspacc_wb_word(oth_acc, 1'b1, q.ctrl[`DSPACC_CC_ROUND_BIT],
		q.ctrl[`DSPACC_CC_DWSAT_BIT]);
	assign st_data = dspacc_wb_word(tgt_acc, req.code == op_store_acc_rounded,
		q.ctrl[`DSPACC_CC_ROUND_BIT], q.ctrl[`DSPACC_CC_DWSAT_BIT]);
	assign rnd_ref = q.acc_a[31:16] + {15'h0000, q.acc_a[15]};

	always_comb
	begin
		d = q;
		d.trap = 1'b0;
		d.wr.valid = 1'b0;
		d.wr.to_pointer = 1'b0;
		d.rdata = 16'h0000;
		if (reg_rd)
		begin
			case (reg_addr)
				`DSPACC_OFS_CORE_CONTROL: d.rdata = {8'h00, q.ctrl};
				`DSPACC_OFS_TRAP_CONTROL: d.rdata = {13'h0000, q.trapc};
				`DSPACC_OFS_STATUS: d.rdata = {10'h000, q.st};
				`DSPACC_OFS_WB_POINTER: d.rdata = q.ptr;
				`DSPACC_OFS_ACC_A_LOW: d.rdata = q.acc_a[15:0];
				`DSPACC_OFS_ACC_A_HIGH: d.rdata = q.acc_a[31:16];
				`DSPACC_OFS_ACC_A_GUARD: d.rdata = {8'h00, q.acc_a[39:32]};
				`DSPACC_OFS_ACC_B_LOW: d.rdata = q.acc_b[15:0];
				`DSPACC_OFS_ACC_B_HIGH: d.rdata = q.acc_b[31:16];
				`DSPACC_OFS_ACC_B_GUARD: d.rdata = {8'h00, q.acc_b[39:32]};
				default: d.rdata = 16'h0000;
			endcase
		end
		if (reg_wr)
		begin
			case (reg_addr)
				`DSPACC_OFS_CORE_CONTROL: d.ctrl = reg_wdata[7:0];
				`DSPACC_OFS_TRAP_CONTROL: d.trapc = reg_wdata[2:0];
				`DSPACC_OFS_WB_POINTER: d.ptr = reg_wdata;
				`DSPACC_OFS_STATUS:
				begin
					if (reg_wdata[`DSPACC_ST_SAT_A_BIT])
						d.st.acc_a_sat_flag = 1'b0;
					if (reg_wdata[`DSPACC_ST_SAT_B_BIT])
						d.st.acc_b_sat_flag = 1'b0;
				end
				default: d.st = d.st;
			endcase
		end
		if (arith_op)
		begin
			if (to_b)
				d.acc_b = res;
			else
				d.acc_a = res;
			d.st.acc_a_guard_ovf = !mode32_a && dspacc_guard_bad(d.acc_a);
			d.st.acc_b_guard_ovf = !mode32_b && dspacc_guard_bad(d.acc_b);
			if (sat_set && to_b)
				d.st.acc_b_sat_flag = 1'b1;
			if (sat_set && !to_b)
				d.st.acc_a_sat_flag = 1'b1;
			d.trap = (d.st.acc_a_guard_ovf && !q.st.acc_a_guard_ovf
				&& q.trapc[`DSPACC_TC_OVF_A_BIT])
				|| (d.st.acc_b_guard_ovf && !q.st.acc_b_guard_ovf
				&& q.trapc[`DSPACC_TC_OVF_B_BIT])
				|| (sat_set && !sat_en && q.trapc[`DSPACC_TC_CAT_BIT]);
		end
		if (wb_go)
		begin
			d.wr.valid = 1'b1;
			d.wr.data = wb_data;
			if (req.wb_indirect)
			begin
				d.wr.addr = q.ptr;
				d.ptr = q.ptr + `DSPACC_PTR_STEP;
			end
			else
			begin
				d.wr.to_pointer = 1'b1;
				d.wr.addr = 16'h0000;
				d.ptr = wb_data;
			end
		end
		if (fire && (req.code inside {op_store_acc_trunc, op_store_acc_rounded}))
		begin
			d.wr.valid = 1'b1;
			d.wr.addr = req.store_addr;
			d.wr.data = st_data;
		end
		if (fire && (req.code == op_shift))
		begin
			d.shift = sh_res;
			d.core_shift = sh_left ? sh_res[15:0] : sh_res[31:16];
		end
		d.st.any_guard_ovf = d.st.acc_a_guard_ovf || d.st.acc_b_guard_ovf;
		d.st.any_sat_flag = d.st.acc_a_sat_flag || d.st.acc_b_sat_flag;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= state_rst;
		else
			q <= d;
	end

	assign reg_rdata = q.rdata;
	assign status = q.st;
	assign trap_req = q.trap;
	assign dwrite = q.wr;
	assign shift_result = q.shift;
	assign core_shift_result = q.core_shift;
	assign acc_a_out = q.acc_a;
	assign acc_b_out = q.acc_b;

	a_sat_sticky: assert property (
		@(posedge clk) disable iff (rst)
		q.st.acc_a_sat_flag && !(reg_wr && (reg_addr == `DSPACC_OFS_STATUS)
		&& reg_wdata[`DSPACC_ST_SAT_A_BIT]) |=> q.st.acc_a_sat_flag)
		else $error("Saturation flag of A dropped without software clear");

	a_guard_mode32: assert property (
		@(posedge clk) disable iff (rst)
		arith_op && mode32_a && mode32_b |=> !status.any_guard_ovf)
		else $error("Guard flag set in 32-bit saturation mode");

	a_sat40_clamp: assert property (
		@(posedge clk) disable iff (rst)
		arith_op && !to_b && sat_en && wide && ov39
		|=> ((q.acc_a == `DSPACC_SAT40_POS) || (q.acc_a == `DSPACC_SAT40_NEG))
		&& q.st.acc_a_sat_flag)
		else $error("40-bit saturation did not clamp accumulator A");

	a_sat32_clamp: assert property (
		@(posedge clk) disable iff (rst)
		arith_op && to_b && sat_en && !wide && ov31
		|=> ((q.acc_b == `DSPACC_SAT32_POS) || (q.acc_b == `DSPACC_SAT32_NEG))
		&& q.st.acc_b_sat_flag)
		else $error("32-bit saturation did not clamp accumulator B");

	a_wrap_catastrophic: assert property (
		@(posedge clk) disable iff (rst)
		arith_op && !to_b && !sat_en && ov39
		|=> (q.acc_a == $past(sum)) && q.st.acc_a_sat_flag)
		else $error("Catastrophic overflow did not wrap and flag");

	a_trap_catastrophic: assert property (
		@(posedge clk) disable iff (rst)
		arith_op && !sat_en && ov39 && q.trapc[`DSPACC_TC_CAT_BIT] |=> trap_req)
		else $error("Catastrophic overflow trap missing");

	a_ptr_step: assert property (
		@(posedge clk) disable iff (rst)
		wb_go && req.wb_indirect
		|=> dwrite.valid && (dwrite.addr == $past(q.ptr))
		&& (q.ptr == $past(q.ptr) + `DSPACC_PTR_STEP))
		else $error("Indirect write-back address or step wrong");

	a_shift_zero: assert property (
		@(posedge clk) disable iff (rst)
		fire && (req.code == op_shift) && (req.shift_amt == 6'sh00)
		&& (req.shift_src == src_acc_a) |=> shift_result == $past(q.acc_a))
		else $error("Zero shift changed the operand");

	a_round_conv: assert property (
		@(posedge clk) disable iff (rst)
		fire && (req.code == op_store_acc_rounded) && !to_b
		&& q.ctrl[`DSPACC_CC_ROUND_BIT] && !q.ctrl[`DSPACC_CC_DWSAT_BIT]
		|=> dwrite.valid && (dwrite.data == $past(rnd_ref)))
		else $error("Conventional rounding result wrong");

	a_guard_trap: assert property (
		@(posedge clk) disable iff (rst)
		$rose(status.acc_a_guard_ovf) && $past(q.trapc[`DSPACC_TC_OVF_A_BIT]) |-> trap_req)
		else $error("Guard overflow trap of A missing");

	a_any_flags: assert property (
		@(posedge clk) disable iff (rst)
		(status.any_guard_ovf == (status.acc_a_guard_ovf || status.acc_b_guard_ovf))
		&& (status.any_sat_flag == (status.acc_a_sat_flag || status.acc_b_sat_flag)))
		else $error("Combined status flags differ from their sources");

	a_dw_clamp_pos: assert property (
		@(posedge clk) disable iff (rst)
		fire && (req.code == op_store_acc_trunc) && q.ctrl[`DSPACC_CC_DWSAT_BIT]
		&& !tgt_acc[39] && (tgt_acc[39:16] > `DSPACC_DW_POS_LIMIT)
		|=> dwrite.valid && (dwrite.data == `DSPACC_DW_POS_MAX))
		else $error("Positive data write not clamped");

	a_dw_clamp_neg: assert property (
		@(posedge clk) disable iff (rst)
		fire && (req.code == op_store_acc_trunc) && q.ctrl[`DSPACC_CC_DWSAT_BIT]
		&& tgt_acc[39] && (tgt_acc[39:16] < `DSPACC_DW_NEG_LIMIT)
		|=> dwrite.valid && (dwrite.data == `DSPACC_DW_NEG_MAX))
		else $error("Negative data write not clamped");

	a_round_tie: assert property (
		@(posedge clk) disable iff (rst)
		fire && (req.code == op_store_acc_rounded) && !to_b
		&& !q.ctrl[`DSPACC_CC_ROUND_BIT] && !q.ctrl[`DSPACC_CC_DWSAT_BIT]
		&& (q.acc_a[16:0] == 17'h08000) |=> dwrite.valid && (dwrite.data == q.acc_a[31:16]))
		else $error("Convergent rounding changed an even tie");

	a_wb_excluded: assert property (
		@(posedge clk) disable iff (rst)
		fire && req.wb_en && (req.code inside {op_multiply_to_acc,
		op_negated_multiply_to_acc, op_distance_squared, op_distance_squared_accumulate})
		|=> !dwrite.valid)
		else $error("Write-back from an excluded operation");

	a_store_keeps_acc: assert property (
		@(posedge clk) disable iff (rst)
		fire && (req.code inside {op_store_acc_trunc, op_store_acc_rounded})
		|=> (q.acc_a == $past(q.acc_a)) && (q.acc_b == $past(q.acc_b)))
		else $error("Store changed an accumulator");
endmodule
`default_nettype wire

// ---- shared/dspacc_params.svh ----
// Constants of the accumulator datapath: offsets, field bits, resets, limits.
// Included by the package user; no code, definitions only.
`ifndef DSPACC_PARAMS_SVH
`define DSPACC_PARAMS_SVH
`define DSPACC_OFS_CORE_CONTROL 4'h0
`define DSPACC_OFS_TRAP_CONTROL 4'h1
`define DSPACC_OFS_STATUS 4'h2
`define DSPACC_OFS_WB_POINTER 4'h3
`define DSPACC_OFS_ACC_A_LOW 4'h4
`define DSPACC_OFS_ACC_A_HIGH 4'h5
`define DSPACC_OFS_ACC_A_GUARD 4'h6
`define DSPACC_OFS_ACC_B_LOW 4'h7
`define DSPACC_OFS_ACC_B_HIGH 4'h8
`define DSPACC_OFS_ACC_B_GUARD 4'h9
`define DSPACC_CC_SAT_A_BIT 7
`define DSPACC_CC_SAT_B_BIT 6
`define DSPACC_CC_DWSAT_BIT 5
`define DSPACC_CC_WIDTH_BIT 4
`define DSPACC_CC_ROUND_BIT 1
`define DSPACC_TC_OVF_A_BIT 0
`define DSPACC_TC_OVF_B_BIT 1
`define DSPACC_TC_CAT_BIT 2
`define DSPACC_ST_SAT_A_BIT 3
`define DSPACC_ST_SAT_B_BIT 2
`define DSPACC_GUARD_MSB 39
`define DSPACC_GUARD_LSB 32
`define DSPACC_CORE_CONTROL_RST 8'h00
`define DSPACC_TRAP_CONTROL_RST 3'h0
`define DSPACC_PTR_RST 16'h0000
`define DSPACC_ACC_RST 40'h0000000000
`define DSPACC_SAT40_POS 40'h7fffffffff
`define DSPACC_SAT40_NEG 40'h8000000000
`define DSPACC_SAT32_POS 40'h007fffffff
`define DSPACC_SAT32_NEG 40'h0080000000
`define DSPACC_DW_POS_LIMIT 24'h007fff
`define DSPACC_DW_NEG_LIMIT 24'hff8000
`define DSPACC_DW_POS_MAX 16'h7fff
`define DSPACC_DW_NEG_MAX 16'h8000
`define DSPACC_RND_HALF 16'h8000
`define DSPACC_PTR_STEP 16'h0002
`endif

// ---- shared/dspacc_pkg.sv ----
// Types of the accumulator datapath.
// Assumes the params header sits beside it on the include path.
`default_nettype none
package dspacc_pkg;
	typedef enum logic [3:0] {
		op_nop = 4'h0,
		op_load_acc = 4'h1,
		op_add_acc = 4'h2,
		op_sub_acc = 4'h3,
		op_multiply_to_acc = 4'h4,
		op_negated_multiply_to_acc = 4'h5,
		op_multiply_accumulate = 4'h6,
		op_multiply_subtract = 4'h7,
		op_distance_squared = 4'h8,
		op_distance_squared_accumulate = 4'h9,
		op_store_acc_trunc = 4'ha,
		op_store_acc_rounded = 4'hb,
		op_shift = 4'hc
	} dspacc_op_type;
	typedef enum logic [1:0] {
		src_acc_a = 2'h0,
		src_acc_b = 2'h1,
		src_xbus = 2'h2
	} dspacc_src_type;
	typedef struct packed {
		logic valid;
		dspacc_op_type code;
		logic target_b;
		dspacc_src_type shift_src;
		logic shift_arith;
		logic signed [5:0] shift_amt;
		logic [15:0] xbus;
		logic [32:0] product;
		logic wb_en;
		logic wb_indirect;
		logic [15:0] store_addr;
	} dspacc_req_type;
	typedef struct packed {
		logic valid;
		logic to_pointer;
		logic [15:0] addr;
		logic [15:0] data;
	} dspacc_dwrite_type;
	typedef struct packed {
		logic acc_a_guard_ovf;
		logic acc_b_guard_ovf;
		logic acc_a_sat_flag;
		logic acc_b_sat_flag;
		logic any_guard_ovf;
		logic any_sat_flag;
	} dspacc_status_type;
	typedef struct packed {
		logic [39:0] acc_a;
		logic [39:0] acc_b;
		dspacc_status_type st;
		logic [7:0] ctrl;
		logic [2:0] trapc;
		logic [15:0] ptr;
		logic [15:0] rdata;
		logic trap;
		dspacc_dwrite_type wr;
		logic [39:0] shift;
		logic [15:0] core_shift;
	} dspacc_state_type;
endpackage
`default_nettype wire
